// file: pkg/iopmc_pkg.sv
package iopmc_pkg;

	// ****************************************
	// Register map (data-space offsets)
	// ****************************************
	localparam logic [7:0] IO_SPACE_BIAS = 8'h20; // Data-space minus this gives I/O space
	localparam logic [7:0] IO_SPACE_TOP = 8'h3F; // Highest I/O-space address
	localparam logic [7:0] OFF_PORT_B_PIN_INPUT = 8'h23;
	localparam logic [7:0] OFF_PORT_B_DIRECTION = 8'h24;
	localparam logic [7:0] OFF_PORT_B_OUTPUT = 8'h25;
	localparam logic [7:0] OFF_PORT_C_PIN_INPUT = 8'h26;
	localparam logic [7:0] OFF_PORT_C_DIRECTION = 8'h27;
	localparam logic [7:0] OFF_PORT_C_OUTPUT = 8'h28;
	localparam logic [7:0] OFF_PORT_D_PIN_INPUT = 8'h29;
	localparam logic [7:0] OFF_PORT_D_DIRECTION = 8'h2A;
	localparam logic [7:0] OFF_PORT_D_OUTPUT = 8'h2B;
	localparam logic [7:0] OFF_MICRO_CONTROL = 8'h55;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int BIT_BROWNOUT_SLEEP_OFF = 6;
	localparam int BIT_BROWNOUT_SLEEP_UNLOCK = 5;
	localparam int BIT_GLOBAL_PULLUP_KILL = 4;
	localparam int BIT_VECTOR_BASE_SELECT = 1;
	localparam int BIT_VECTOR_CHANGE_UNLOCK = 0;
	localparam logic [7:0] RST_PORT = 8'h00; // Output and direction reset
	localparam logic [7:0] RST_MICRO_CONTROL = 8'h00;
	localparam logic [7:0] PORT_C_MASK = 8'h7F; // Port C has bits 0..6 only
	localparam logic [7:0] PORT_FULL_MASK = 8'hFF;
	localparam int NUM_PORTS = 3;

	// ****************************************
	// Timing counts, in clock cycles
	// ****************************************
	localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4; // Timed-sequence window
	localparam logic [2:0] BROWNOUT_ACTIVE_CYC = 3'h3; // Delay until sleep bit acts
	localparam logic [2:0] BROWNOUT_CLEAR_CYC = 3'h3; // Auto clear after set
	localparam logic [2:0] VSEL_HOLDOFF_CYC = 3'h2; // Write cycle plus next instruction

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed
	{
		logic [7:0] output_data;
		logic [7:0] direction;
	} iopmc_port_s;

	typedef struct packed
	{
		logic strobe_wr;
		logic strobe_rd;
		logic io_space;
		logic [7:0] addr;
		logic [7:0] wdata;
	} iopmc_cpu_req_s;

	typedef enum logic [1:0]
	{
		VC_IDLE,
		VC_UNLOCKED,
		VC_HOLDOFF
	} iopmc_vc_state_e;

endpackage

// file: hdl/iopmc_sync_port.sv
`timescale 1ns/10ps
// Two-flop synchroniser plus per-pin pad control for one port
module iopmc_sync_port
	import iopmc_pkg::*;
#(
	parameter logic [7:0] IMPL_MASK = 8'hFF
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] pin_raw,
	input wire iopmc_port_s port_cfg,
	input wire logic pullup_kill,
	output logic [7:0] pin_sync,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe_n,
	output logic [7:0] pad_pullup
);

	logic [7:0] meta_q; // First stage, read only by second stage
	logic [7:0] sync_q;

	// ****************************************
	// Input synchroniser
	// ****************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= 8'h00;
			sync_q <= 8'h00;
		end
		else
		begin
			meta_q <= pin_raw;
			sync_q <= meta_q;
		end
	end

	assign pin_sync = sync_q & IMPL_MASK;

	// ****************************************
	// Per-pin pad drive
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_pin
			// Each pin follows only its own direction bit
			assign pad_out[g] = port_cfg.output_data[g] & IMPL_MASK[g];
			assign pad_oe_n[g] = ~(port_cfg.direction[g] & IMPL_MASK[g]);
			// Pull-up only for input with output bit one, and never when killed
			assign pad_pullup[g] = IMPL_MASK[g] & ~port_cfg.direction[g]
				& port_cfg.output_data[g] & ~pullup_kill;
		end
	endgenerate

endmodule

// file: hdl/iopmc_top.sv
`timescale 1ns/10ps
// How it works
// - Decode data-space offset and offset minus 0x20
// - Sleep bit active after three, cleared after three
// - Detector off only if sleep while active
// - Brown-out sleep feature exists on one variant
// - Pull-up kill overrides every port pull-up
// - Vector select picks flash start or boot
// - Boot base comes from boot size fuses
// - Interrupts blocked during vector change sequence
// - Global interrupt enable bit left untouched
// - Change unlock clears after three or select
// - Lock bits block interrupts in other section
// - Direction bit steers its own pin only
// - Port C implements bits zero to six
// - Pin register write toggles, read returns pins
module iopmc_top
	import iopmc_pkg::*;
#(
	parameter bit HAS_BROWNOUT_SLEEP = 1'b1, // Variant with sleep-disable feature
	parameter int PC_WIDTH = 14 // Program counter width in bits, counting words
)
(
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	input wire iopmc_cpu_req_s I_CPU_REQ,
	output logic [7:0] O_CPU_RDATA,
	input wire logic I_SLEEP_EXEC,
	input wire logic [1:0] I_BOOT_SIZE_FUSES,
	input wire logic I_APP_SECTION_LOCK_BIT,
	input wire logic I_BOOT_SECTION_LOCK_BIT,
	input wire logic I_EXEC_IN_BOOT,
	input wire logic [23:0] I_PIN_RAW,
	output logic [23:0] O_PAD_OUT,
	output logic [23:0] O_PAD_OE_N,
	output logic [23:0] O_PAD_PULLUP,
	output logic O_GLOBAL_PULLUP_KILL,
	output logic O_BROWNOUT_SLEEP_ACTIVE,
	output logic O_BROWNOUT_DETECTOR_OFF,
	output logic O_VECTOR_BASE_SELECT,
	output logic [PC_WIDTH-1:0] O_VECTOR_BASE,
	output logic O_IRQ_BLOCK
);

	// ****************************************
	// Address decode
	// ****************************************
	// Folds both address spaces onto the data-space offset
	// An I/O-space address above the top maps to an unused offset, so
	// a stray instruction can never alias onto a data-space register
	function automatic logic [7:0] norm_addr(input logic io_sp, input logic [7:0] a);
		logic [7:0] r;
		r = a;
		if (io_sp)
			r = (a <= IO_SPACE_TOP) ? a + IO_SPACE_BIAS : 8'hFF;
		return r;
	endfunction

	// Decoded write strobe for one offset
	function automatic logic wr_hit(input iopmc_cpu_req_s q, input logic [7:0] off);
		return q.strobe_wr && (norm_addr(q.io_space, q.addr) == off);
	endfunction

	// Reads decode once here; writes decode through wr_hit per register
	logic [7:0] dev_addr; // Normalised address
	logic [7:0] wd; // Write data
	assign dev_addr = norm_addr(I_CPU_REQ.io_space, I_CPU_REQ.addr);
	assign wd = I_CPU_REQ.wdata;

	// ****************************************
	// Port registers
	// ****************************************
	iopmc_port_s port_q [NUM_PORTS]; // Output and direction per port
	logic [7:0] pin_sync [NUM_PORTS]; // Synchronised pin levels
	localparam logic [7:0] OFF_PIN [NUM_PORTS] =
		'{OFF_PORT_B_PIN_INPUT, OFF_PORT_C_PIN_INPUT, OFF_PORT_D_PIN_INPUT};
	localparam logic [7:0] OFF_DIR [NUM_PORTS] =
		'{OFF_PORT_B_DIRECTION, OFF_PORT_C_DIRECTION, OFF_PORT_D_DIRECTION};
	localparam logic [7:0] OFF_OUT [NUM_PORTS] =
		'{OFF_PORT_B_OUTPUT, OFF_PORT_C_OUTPUT, OFF_PORT_D_OUTPUT};
	localparam logic [7:0] IMPL [NUM_PORTS] = '{PORT_FULL_MASK, PORT_C_MASK, PORT_FULL_MASK};

	// Pull-up kill lives in the control register but gates every port,
	// so it is declared ahead of the port generate loop
	logic pullup_kill_q; // Global pull-up disable

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++)
		begin : g_port
			// Output and direction; a pin-register write toggles output bits
			// A toggle write leaves direction alone; only output data flips
			always_ff @(posedge I_REF_CLK or posedge I_RESET)
			begin
				if (I_RESET)
				begin
					port_q[p] <= '{output_data: RST_PORT, direction: RST_PORT};
				end
				else
				begin
					if (wr_hit(I_CPU_REQ, OFF_OUT[p]))
						port_q[p].output_data <= wd & IMPL[p];
					else if (wr_hit(I_CPU_REQ, OFF_PIN[p]))
						// Ones invert, zeros leave the bit alone
						port_q[p].output_data <= port_q[p].output_data ^ (wd & IMPL[p]);
					if (wr_hit(I_CPU_REQ, OFF_DIR[p]))
						port_q[p].direction <= wd & IMPL[p];
				end
			end

			// Pad control and synchronised pins
			iopmc_sync_port #(
				.IMPL_MASK(IMPL[p])
			) u_port (
				.clk(I_REF_CLK),
				.rst(I_RESET),
				.pin_raw(I_PIN_RAW[8*p +: 8]),
				.port_cfg(port_q[p]),
				.pullup_kill(pullup_kill_q),
				.pin_sync(pin_sync[p]),
				.pad_out(O_PAD_OUT[8*p +: 8]),
				.pad_oe_n(O_PAD_OE_N[8*p +: 8]),
				.pad_pullup(O_PAD_PULLUP[8*p +: 8])
			);
		end
	endgenerate

	// ****************************************
	// Control register decode
	// ****************************************
	logic mc_wr; // Write to the control register
	assign mc_wr = wr_hit(I_CPU_REQ, OFF_MICRO_CONTROL);

	// Pull-up kill is a plain read/write bit
	always_ff @(posedge I_REF_CLK or posedge I_RESET)
	begin
		if (I_RESET)
			pullup_kill_q <= RST_MICRO_CONTROL[BIT_GLOBAL_PULLUP_KILL];
		else if (mc_wr)
			pullup_kill_q <= wd[BIT_GLOBAL_PULLUP_KILL];
	end

	// ****************************************
	// Brown-out sleep timed sequence
	// ****************************************
	logic brownout_sleep_off_unlock_q; // Unlock window open
	logic [2:0] brownout_sleep_off_unlock_cnt_q; // Cycles left in unlock window
	logic brownout_sleep_off_q; // Sleep-off bit as read back
	logic [2:0] brownout_sleep_off_age_q; // Cycles since sleep-off bit was set
	logic brownout_sleep_off_arm; // Second write of the sequence

	assign brownout_sleep_off_arm = mc_wr && brownout_sleep_off_unlock_q && wd[BIT_BROWNOUT_SLEEP_OFF]
		&& !wd[BIT_BROWNOUT_SLEEP_UNLOCK];

	// The window counter is loaded with the full count and the unlock drops
	// on the last count, so a late second write is simply ignored
	// Unlock opens on a write of both bits and lapses after the window
	always_ff @(posedge I_REF_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			brownout_sleep_off_unlock_q <= 1'b0;
			brownout_sleep_off_unlock_cnt_q <= 3'h0;
		end
		else if (!HAS_BROWNOUT_SLEEP)
		begin
			// Variant without the feature: bits stay zero
			brownout_sleep_off_unlock_q <= 1'b0;
			brownout_sleep_off_unlock_cnt_q <= 3'h0;
		end
		else if (mc_wr && wd[BIT_BROWNOUT_SLEEP_OFF] && wd[BIT_BROWNOUT_SLEEP_UNLOCK])
		begin
			brownout_sleep_off_unlock_q <= 1'b1;
			brownout_sleep_off_unlock_cnt_q <= UNLOCK_WINDOW_CYC;
		end
		else if (brownout_sleep_off_arm || (brownout_sleep_off_unlock_q && brownout_sleep_off_unlock_cnt_q == 3'h1))
		begin
			brownout_sleep_off_unlock_q <= 1'b0;
			brownout_sleep_off_unlock_cnt_q <= 3'h0;
		end
		else if (brownout_sleep_off_unlock_q)
			brownout_sleep_off_unlock_cnt_q <= brownout_sleep_off_unlock_cnt_q - 3'h1;
	end

	// A fresh arm restarts the age, so the bit cannot act early on a repeat
	// Sleep-off bit counts its age; acts at three, clears at three
	always_ff @(posedge I_REF_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			brownout_sleep_off_q <= 1'b0;
			brownout_sleep_off_age_q <= 3'h0;
		end
		else if (brownout_sleep_off_arm && HAS_BROWNOUT_SLEEP)
		begin
			brownout_sleep_off_q <= 1'b1;
			brownout_sleep_off_age_q <= 3'h0;
		end
		else if (brownout_sleep_off_q && brownout_sleep_off_age_q == BROWNOUT_CLEAR_CYC - 3'h1)
		begin
			brownout_sleep_off_q <= 1'b0;
			brownout_sleep_off_age_q <= 3'h0;
		end
		else if (brownout_sleep_off_q)
			brownout_sleep_off_age_q <= brownout_sleep_off_age_q + 3'h1;
	end

	// Active in the last cycle before the automatic clear
	assign O_BROWNOUT_SLEEP_ACTIVE = brownout_sleep_off_q
		&& (brownout_sleep_off_age_q == BROWNOUT_ACTIVE_CYC - 3'h1);

	// Holding the request until wake keeps the detector off for the whole
	// sleep period, not just the cycle in which sleep began
	// Detector off latched on sleep while active, released on wake
	always_ff @(posedge I_REF_CLK or posedge I_RESET)
	begin
		if (I_RESET)
			O_BROWNOUT_DETECTOR_OFF <= 1'b0;
		else if (I_SLEEP_EXEC && O_BROWNOUT_SLEEP_ACTIVE)
			O_BROWNOUT_DETECTOR_OFF <= 1'b1;
		else if (!I_SLEEP_EXEC)
			O_BROWNOUT_DETECTOR_OFF <= 1'b0;
	end

	// ****************************************
	// Vector select timed sequence
	// ****************************************
	iopmc_vc_state_e vc_state_q; // Sequence state
	logic [2:0] vc_cnt_q; // Cycle counter for window or hold-off
	logic vsel_q; // Vector base select
	logic vsel_wr; // Second write of the sequence

	assign vsel_wr = mc_wr && (vc_state_q == VC_UNLOCKED)
		&& !wd[BIT_VECTOR_CHANGE_UNLOCK];

	// A fresh unlock write always wins over the running count, so software
	// retrying the sequence gets a full window again
	// Unlock, then either select write with short hold-off or timeout
	always_ff @(posedge I_REF_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			vc_state_q <= VC_IDLE;
			vc_cnt_q <= 3'h0;
		end
		else if (mc_wr && wd[BIT_VECTOR_CHANGE_UNLOCK])
		begin
			// Each unlock write restarts the window
			vc_state_q <= VC_UNLOCKED;
			vc_cnt_q <= UNLOCK_WINDOW_CYC - 3'h1;
		end
		else
		begin
			case (vc_state_q)
				VC_IDLE:
					vc_cnt_q <= 3'h0;
				VC_UNLOCKED:
					if (vsel_wr)
					begin
						// Keep blocking through the next instruction
						vc_state_q <= VC_HOLDOFF;
						vc_cnt_q <= VSEL_HOLDOFF_CYC - 3'h1;
					end
					else if (vc_cnt_q == 3'h1)
						vc_state_q <= VC_IDLE;
					else
						vc_cnt_q <= vc_cnt_q - 3'h1;
				VC_HOLDOFF:
					if (vc_cnt_q <= 3'h1)
						vc_state_q <= VC_IDLE;
					else
						vc_cnt_q <= vc_cnt_q - 3'h1;
				default:
					vc_state_q <= VC_IDLE;
			endcase
		end
	end

	// Select bit changes only through the sequence
	always_ff @(posedge I_REF_CLK or posedge I_RESET)
	begin
		if (I_RESET)
			vsel_q <= RST_MICRO_CONTROL[BIT_VECTOR_BASE_SELECT];
		else if (vsel_wr)
			vsel_q <= wd[BIT_VECTOR_BASE_SELECT];
	end

	assign O_VECTOR_BASE_SELECT = vsel_q;

	// Boot section start: larger fuse code means smaller boot area
	// Fuse code zero gives the largest boot area and the lowest base
	logic [PC_WIDTH-1:0] boot_base; // Word address of boot start
	always_comb
	begin
		boot_base = '1 << (8 + 3 - I_BOOT_SIZE_FUSES);
	end
	assign O_VECTOR_BASE = vsel_q ? boot_base : '0;

	// Blocking includes the cycle of the unlock write; it never touches the I-bit
	// Lock-bit blocking follows the live inputs combinationally, so a change
	// of execution section takes effect at once
	logic vc_block; // Sequence blocking term
	assign vc_block = (mc_wr && wd[BIT_VECTOR_CHANGE_UNLOCK]) || (vc_state_q != VC_IDLE);
	assign O_IRQ_BLOCK = vc_block
		|| (vsel_q && I_APP_SECTION_LOCK_BIT && !I_EXEC_IN_BOOT)
		|| (!vsel_q && I_BOOT_SECTION_LOCK_BIT && I_EXEC_IN_BOOT);
	assign O_GLOBAL_PULLUP_KILL = pullup_kill_q;

	// ****************************************
	// Read data
	// ****************************************
	// Bits 7, 3 and 2 are not implemented and read as zero
	logic [7:0] mc_view; // Control register as read
	always_comb
	begin
		mc_view = 8'h00;
		mc_view[BIT_BROWNOUT_SLEEP_OFF] = brownout_sleep_off_q;
		mc_view[BIT_BROWNOUT_SLEEP_UNLOCK] = brownout_sleep_off_unlock_q;
		mc_view[BIT_GLOBAL_PULLUP_KILL] = pullup_kill_q;
		mc_view[BIT_VECTOR_BASE_SELECT] = vsel_q;
		mc_view[BIT_VECTOR_CHANGE_UNLOCK] = (vc_state_q == VC_UNLOCKED);
	end

	// Registered read; unmapped addresses read zero
	// Later matches in the loop override the default, one offset per register
	always_ff @(posedge I_REF_CLK or posedge I_RESET)
	begin
		if (I_RESET)
			O_CPU_RDATA <= 8'h00;
		else if (I_CPU_REQ.strobe_rd)
		begin
			O_CPU_RDATA <= (dev_addr == OFF_MICRO_CONTROL) ? mc_view : 8'h00;
			for (int i = 0; i < NUM_PORTS; i++)
			begin
				if (dev_addr == OFF_PIN[i])
					O_CPU_RDATA <= pin_sync[i];
				if (dev_addr == OFF_DIR[i])
					O_CPU_RDATA <= port_q[i].direction;
				if (dev_addr == OFF_OUT[i])
					O_CPU_RDATA <= port_q[i].output_data;
			end
		end
	end

endmodule

// file: test/iopmc_assertions.sv
`timescale 1ns/10ps
// ****
// Port-level checker
// ****
module iopmc_assertions
	import iopmc_pkg::*;
#(
	parameter bit HAS_BROWNOUT_SLEEP = 1'b1,
	parameter int PC_WIDTH = 14
)
(
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	input wire iopmc_cpu_req_s I_CPU_REQ,
	input wire logic I_SLEEP_EXEC,
	input wire logic [1:0] I_BOOT_SIZE_FUSES,
	input wire logic I_APP_SECTION_LOCK_BIT,
	input wire logic I_BOOT_SECTION_LOCK_BIT,
	input wire logic I_EXEC_IN_BOOT,
	input wire logic [23:0] O_PAD_OUT,
	input wire logic [23:0] O_PAD_OE_N,
	input wire logic [23:0] O_PAD_PULLUP,
	input wire logic O_GLOBAL_PULLUP_KILL,
	input wire logic O_BROWNOUT_SLEEP_ACTIVE,
	input wire logic O_BROWNOUT_DETECTOR_OFF,
	input wire logic O_VECTOR_BASE_SELECT,
	input wire logic [PC_WIDTH-1:0] O_VECTOR_BASE,
	input wire logic O_IRQ_BLOCK
);
	logic [7:0] dadr; // Request address in data space
	logic mc_wr; // Control register write
	logic pb_wr; // Port B pin register write
	logic [PC_WIDTH-1:0] base_x; // Expected boot vector base
	assign dadr = I_CPU_REQ.io_space ? I_CPU_REQ.addr + IO_SPACE_BIAS : I_CPU_REQ.addr;
	assign mc_wr = I_CPU_REQ.strobe_wr && (dadr == OFF_MICRO_CONTROL);
	assign pb_wr = I_CPU_REQ.strobe_wr && (dadr == OFF_PORT_B_PIN_INPUT);
	assign base_x = {PC_WIDTH{1'b1}} << (4'hB - I_BOOT_SIZE_FUSES);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_RESET);
	// Lock inputs low, else the block comes from them too
	sequence vc_arm;
		mc_wr && I_CPU_REQ.wdata[0] && !I_APP_SECTION_LOCK_BIT && !I_BOOT_SECTION_LOCK_BIT;
	endsequence
	sequence bod_arm;
		mc_wr && I_CPU_REQ.wdata[6:5] == 2'h3;
	endsequence
	sequence bod_go;
		mc_wr && I_CPU_REQ.wdata[6:5] == 2'h2;
	endsequence
	chk_bod_timing: assert property (bod_arm ##1 bod_go |-> ##3
		(O_BROWNOUT_SLEEP_ACTIVE == HAS_BROWNOUT_SLEEP) ##1 !O_BROWNOUT_SLEEP_ACTIVE)
		else $error("sleep bit timing wrong");
	chk_bod_off: assert property (O_BROWNOUT_SLEEP_ACTIVE && I_SLEEP_EXEC
		|=> O_BROWNOUT_DETECTOR_OFF) else $error("detector not off");
	chk_bod_cause: assert property ($rose(O_BROWNOUT_DETECTOR_OFF)
		|-> $past(O_BROWNOUT_SLEEP_ACTIVE)) else $error("detector off without cause");
	chk_kill_pullup: assert property (O_GLOBAL_PULLUP_KILL
		|-> O_PAD_PULLUP == 24'h000000) else $error("pull-up despite kill");
	chk_pullup_pair: assert property (!O_GLOBAL_PULLUP_KILL
		|-> O_PAD_PULLUP == (O_PAD_OE_N & O_PAD_OUT)) else $error("pull-up pair wrong");
	chk_port_c_output_top: assert property (!O_PAD_OUT[15] && O_PAD_OE_N[15]
		&& !O_PAD_PULLUP[15]) else $error("port C bit 7 active");
	chk_vce_block: assert property (vc_arm |-> O_IRQ_BLOCK[*3])
		else $error("block too short");
	chk_block_end: assert property (vc_arm ##1 !mc_wr [*3] |=> !O_IRQ_BLOCK)
		else $error("block too long");
	chk_vsel_take: assert property (vc_arm ##1 mc_wr |-> O_IRQ_BLOCK ##1
		(O_IRQ_BLOCK && O_VECTOR_BASE_SELECT == $past(I_CPU_REQ.wdata[1])) ##1 !O_IRQ_BLOCK)
		else $error("vector select sequence wrong");
	chk_vec_base: assert property (O_VECTOR_BASE
		== (O_VECTOR_BASE_SELECT ? base_x : '0)) else $error("vector base wrong");
	chk_irq_lock: assert property ((O_VECTOR_BASE_SELECT && I_APP_SECTION_LOCK_BIT
		&& !I_EXEC_IN_BOOT) || (!O_VECTOR_BASE_SELECT && I_BOOT_SECTION_LOCK_BIT
		&& I_EXEC_IN_BOOT) |-> O_IRQ_BLOCK) else $error("lock block missing");
	chk_pin_toggle: assert property (pb_wr |=> O_PAD_OUT[7:0]
		== ($past(O_PAD_OUT[7:0]) ^ $past(I_CPU_REQ.wdata))) else $error("toggle wrong");
endmodule

// file: test/iopmc_pin_model.sv
`timescale 1ns/10ps
// ****
// Board pins: driven, pulled up, forced or floating
// ****
module iopmc_pin_model
(
	input wire logic clk,
	input wire logic [23:0] pad_out,
	input wire logic [23:0] pad_oe_n,
	input wire logic [23:0] pad_pullup,
	input wire logic [23:0] ext_en,
	input wire logic [23:0] ext_val,
	output logic [23:0] pin
);
	logic flip = 1'b0; // Floating pins wander, so no stale level is read
	always @(posedge clk) flip <= ~flip;
	assign pin = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
		| (pad_oe_n & ~ext_en & (pad_pullup | {24{flip}}));
endmodule

// file: test/iopmc_tb_top.sv
`timescale 1ns/10ps
module iopmc_tb_top
	import iopmc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	iopmc_cpu_req_s req = '0;
	logic [7:0] rdata, a, d, m;
	logic sleep = 1'b0;
	logic [1:0] fuses = 2'h0;
	logic app_lock = 1'b0;
	logic boot_lock = 1'b0;
	logic in_boot = 1'b0;
	logic [23:0] pins, pad_out, oe_n, pull;
	logic [23:0] ext_en = 24'hFFFFFF; // Board drives every undriven pin
	logic [23:0] ext_val = 24'hA5C35A;
	logic kill, bod_act, bod_off, vsel, irq_blk;
	logic [13:0] vbase;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #25 clk = ~clk;
	iopmc_top #(.HAS_BROWNOUT_SLEEP(1'b1), .PC_WIDTH(14)) u_dut (.I_REF_CLK(clk),
		.I_RESET(rst), .I_CPU_REQ(req), .O_CPU_RDATA(rdata), .I_SLEEP_EXEC(sleep),
		.I_BOOT_SIZE_FUSES(fuses), .I_APP_SECTION_LOCK_BIT(app_lock),
		.I_BOOT_SECTION_LOCK_BIT(boot_lock), .I_EXEC_IN_BOOT(in_boot), .I_PIN_RAW(pins),
		.O_PAD_OUT(pad_out), .O_PAD_OE_N(oe_n), .O_PAD_PULLUP(pull),
		.O_GLOBAL_PULLUP_KILL(kill), .O_BROWNOUT_SLEEP_ACTIVE(bod_act),
		.O_BROWNOUT_DETECTOR_OFF(bod_off), .O_VECTOR_BASE_SELECT(vsel),
		.O_VECTOR_BASE(vbase), .O_IRQ_BLOCK(irq_blk));
	iopmc_pin_model u_pins (.clk(clk), .pad_out(pad_out), .pad_oe_n(oe_n),
		.pad_pullup(pull), .ext_en(ext_en), .ext_val(ext_val), .pin(pins));
	logic [7:0] rdata_lite; // Variant without the brown-out sleep feature
	logic bod_act_lite;
	iopmc_top #(.HAS_BROWNOUT_SLEEP(1'b0), .PC_WIDTH(14)) u_dut_lite (.I_REF_CLK(clk),
		.I_RESET(rst), .I_CPU_REQ(req), .O_CPU_RDATA(rdata_lite), .I_SLEEP_EXEC(sleep),
		.I_BOOT_SIZE_FUSES(fuses), .I_APP_SECTION_LOCK_BIT(app_lock),
		.I_BOOT_SECTION_LOCK_BIT(boot_lock), .I_EXEC_IN_BOOT(in_boot), .I_PIN_RAW(pins),
		.O_PAD_OUT(), .O_PAD_OE_N(), .O_PAD_PULLUP(), .O_GLOBAL_PULLUP_KILL(),
		.O_BROWNOUT_SLEEP_ACTIVE(bod_act_lite), .O_BROWNOUT_DETECTOR_OFF(),
		.O_VECTOR_BASE_SELECT(), .O_VECTOR_BASE(), .O_IRQ_BLOCK());
	// ****
	// Access tasks: request set after an edge, taken at the next one
	// ****
	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		cmp_count++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic io, input logic [7:0] ad, input logic [7:0] dt);
		req = '{1'b1, 1'b0, io, io ? ad - IO_SPACE_BIAS : ad, dt};
		@(posedge clk);
		#1;
	endtask
	task automatic rdc(input logic io, input logic [7:0] ad, input logic [7:0] e);
		req = '{1'b0, 1'b1, io, io ? ad - IO_SPACE_BIAS : ad, 8'h00};
		@(posedge clk);
		#1;
		chk(rdata, e);
	endtask
	task automatic idle(input int n);
		req = '0;
		repeat (n)
		begin
			@(posedge clk);
			#1;
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog: the whole sequence needs about a hundred cycles
	initial
	begin
		#(50 * 3000);
		n_mismatch++;
		report_and_stop();
	end
	// ****
	// Test sequence
	// ****
	initial
	begin
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		idle(3);
		chk(oe_n, 24'hFFFFFF);
		rdc(1'b0, 8'h30, 8'h00);
		rdc(1'b1, OFF_MICRO_CONTROL, RST_MICRO_CONTROL);
		// Both address spaces, pad control, pin sampling and toggling per port
		for (int k = 0; k < 3; k++)
		begin
			m = (k == 1) ? PORT_C_MASK : PORT_FULL_MASK;
			a = OFF_PORT_B_DIRECTION + 8'(3 * k);
			d = 8'h0F ^ 8'(k * 17);
			rdc(1'b1, a - 8'h1, ext_val[8 * k +: 8] & m);
			rdc(1'b0, a, RST_PORT);
			wr(1'b1, a, d);
			wr(1'b0, a + 8'h1, 8'hF5);
			idle(3);
			rdc(1'b0, a, d & m);
			rdc(1'b1, a + 8'h1, 8'hF5 & m);
			chk(oe_n[8 * k +: 8], 8'(~(d & m)));
			chk(pull[8 * k +: 8], 8'(~d & 8'hF5 & m));
			rdc(1'b0, a - 8'h1, 8'(((d & 8'hF5) | (~d & ext_val[8 * k +: 8])) & m));
			wr(1'b0, a - 8'h1, 8'hFF);
			wr(1'b1, a - 8'h1, 8'h81);
			rdc(1'b0, a + 8'h1, 8'h8B & m);
		end
		// Port B top pin left to its pull-up, bits 6..4 from the board
		ext_en = 24'hFFFF70;
		idle(3);
		rdc(1'b0, OFF_PORT_B_PIN_INPUT, 8'hDB);
		chk(rdata & 8'h8F, 8'h8B);
		wr(1'b0, OFF_MICRO_CONTROL, 8'h10);
		idle(1);
		chk(kill, 1'b1);
		chk(pull, 24'h000000);
		rdc(1'b1, OFF_MICRO_CONTROL, 8'h10);
		wr(1'b0, OFF_MICRO_CONTROL, 8'h00);
		ext_en = 24'hFFFFFF;
		// Vector move, timely then late, then back
		wr(1'b1, OFF_MICRO_CONTROL, 8'h01);
		chk(irq_blk, 1'b1);
		wr(1'b1, OFF_MICRO_CONTROL, 8'h02);
		chk(irq_blk, 1'b1);
		idle(1);
		chk({irq_blk, vsel}, 2'h1);
		for (int f = 0; f < 4; f++)
		begin
			fuses = 2'(f);
			idle(1);
			chk(vbase, 14'(14'h3FFF << (11 - f)));
		end
		app_lock = 1'b1;
		idle(1);
		chk(irq_blk, 1'b1);
		in_boot = 1'b1;
		idle(1);
		chk(irq_blk, 1'b0);
		app_lock = 1'b0;
		in_boot = 1'b0;
		wr(1'b0, OFF_MICRO_CONTROL, 8'h03);
		idle(2);
		rdc(1'b0, OFF_MICRO_CONTROL, 8'h03);
		rdc(1'b0, OFF_MICRO_CONTROL, 8'h02);
		wr(1'b0, OFF_MICRO_CONTROL, 8'h01);
		idle(4);
		wr(1'b0, OFF_MICRO_CONTROL, 8'h00);
		idle(1);
		chk(vsel, 1'b1);
		wr(1'b0, OFF_MICRO_CONTROL, 8'h01);
		wr(1'b0, OFF_MICRO_CONTROL, 8'h00);
		idle(2);
		chk({vsel, vbase}, 15'h0);
		boot_lock = 1'b1;
		in_boot = 1'b1;
		idle(1);
		chk(irq_blk, 1'b1);
		boot_lock = 1'b0;
		in_boot = 1'b0;
		// Brown-out sleep: armed, used, then refused when late
		wr(1'b0, OFF_MICRO_CONTROL, 8'h60);
		wr(1'b0, OFF_MICRO_CONTROL, 8'h40);
		rdc(1'b0, OFF_MICRO_CONTROL, 8'h40);
		chk(rdata_lite, 8'h00);
		idle(1);
		chk(bod_act, 1'b1);
		chk(bod_act_lite, 1'b0);
		sleep = 1'b1;
		idle(1);
		chk({bod_off, bod_act}, 2'h2);
		rdc(1'b0, OFF_MICRO_CONTROL, 8'h00);
		sleep = 1'b0;
		idle(1);
		chk(bod_off, 1'b0);
		sleep = 1'b1;
		idle(2);
		chk(bod_off, 1'b0);
		sleep = 1'b0;
		wr(1'b0, OFF_MICRO_CONTROL, 8'h60);
		idle(4);
		wr(1'b0, OFF_MICRO_CONTROL, 8'h40);
		rdc(1'b0, OFF_MICRO_CONTROL, 8'h00);
		// Reset in mid-run
		rst = 1'b1;
		idle(2);
		rst = 1'b0;
		idle(1);
		chk(oe_n, 24'hFFFFFF);
		rdc(1'b1, OFF_PORT_D_OUTPUT, RST_PORT);
		report_and_stop();
	end
endmodule
bind iopmc_top iopmc_assertions #(.HAS_BROWNOUT_SLEEP(HAS_BROWNOUT_SLEEP),
	.PC_WIDTH(PC_WIDTH)) u_chk (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET),
	.I_CPU_REQ(I_CPU_REQ), .I_SLEEP_EXEC(I_SLEEP_EXEC),
	.I_BOOT_SIZE_FUSES(I_BOOT_SIZE_FUSES), .I_APP_SECTION_LOCK_BIT(I_APP_SECTION_LOCK_BIT),
	.I_BOOT_SECTION_LOCK_BIT(I_BOOT_SECTION_LOCK_BIT), .I_EXEC_IN_BOOT(I_EXEC_IN_BOOT),
	.O_PAD_OUT(O_PAD_OUT), .O_PAD_OE_N(O_PAD_OE_N), .O_PAD_PULLUP(O_PAD_PULLUP),
	.O_GLOBAL_PULLUP_KILL(O_GLOBAL_PULLUP_KILL),
	.O_BROWNOUT_SLEEP_ACTIVE(O_BROWNOUT_SLEEP_ACTIVE),
	.O_BROWNOUT_DETECTOR_OFF(O_BROWNOUT_DETECTOR_OFF),
	.O_VECTOR_BASE_SELECT(O_VECTOR_BASE_SELECT), .O_VECTOR_BASE(O_VECTOR_BASE),
	.O_IRQ_BLOCK(O_IRQ_BLOCK));
